// file: hw/gauge_pkg.sv
// Purpose: shared constants and types of the battery gauge core.
// Assumes: 20 MHz system clock, 32,768 Hz conversion time base.
// Notes: register pointer values are the byte addresses of the serial port.
// Operation
// - each current conversion result is added into a 28-bit charge accumulator.
// - host sees only the upper 16 accumulator bits.
// - 16-bit conversion counter counts completed current conversions.
// - current results are two's complement, accumulated and reported signed.
// - latest current result is loaded into the readable current registers.
// - offset_calibrate shorts converter inputs to measure its own offset.
// - n-bit current conversion lasts 2^n time-base cycles, n from 12 to 14.
// - undervoltage stops the gauge and holds standby, registers kept.
// - power-on reset returns all registers except the RAM bytes to defaults.
// - time base comes from internal oscillator or external clock input.
// - voltage/temperature conversion every two seconds, alternating, four-second refresh.
// - each voltage or temperature conversion lasts 8192 time-base cycles.
// - gpio_level_bit 0 drives gpio_pin low, 1 releases it.
// - reading gpio_level_bit returns the sampled gpio_pin level.
// - standby, por_flag or power-down release gpio_pin and read zero.
// - 32 read/write RAM bytes kept through standby and low voltage.
// - 8-byte identity: part code, 48-bit random number, checksum.
// - checksum is CRC-8 x8+x2+x+1 over bytes 0..6, initial zero.
// - identity copied from nonvolatile store at power-up, then fixed.
// - serial port is an I2C slave to 400 kbit/s with data-line spike filter.
// - slave address is 1110 plus three select bits, default 70h.
// - address byte, register pointer, then data bytes, each acknowledged, MSB first.
// - gauge_resolution 00 gives 14 bits, 01 gives 13, 10 gives 12.
// - gauge_clear zeroes accumulator and counter, then clears itself.
// - current_done_flag sets at conversion end, clears when host reads it.
package gauge_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned TB_HZ = 32_768;
    localparam int unsigned TB_DIV = CLK_HZ / TB_HZ;
    localparam logic [9:0] TB_DIV_M1 = 10'(TB_DIV - 1);
    localparam int unsigned VT_PERIOD_S = 2;
    localparam int unsigned VT_CONV_MS = 250;
    localparam logic [15:0] VT_PERIOD_M1 = 16'(VT_PERIOD_S * TB_HZ - 1);
    localparam logic [15:0] VT_CONV_M1 = 16'(VT_CONV_MS * TB_HZ / 1000 - 1);
    localparam logic [13:0] CUR_LEN14_M1 = 14'h3FFF;
    localparam logic [13:0] CUR_LEN13_M1 = 14'h1FFF;
    localparam logic [13:0] CUR_LEN12_M1 = 14'h0FFF;
    localparam int unsigned ACC_W = 28;
    localparam int unsigned CHG_LSB = ACC_W - 16;
    localparam logic [7:0] REG_MODE = 8'h00;
    localparam logic [7:0] REG_CTRL = 8'h01;
    localparam logic [7:0] REG_CHG_LO = 8'h02;
    localparam logic [7:0] REG_CHG_HI = 8'h03;
    localparam logic [7:0] REG_CNT_LO = 8'h04;
    localparam logic [7:0] REG_CNT_HI = 8'h05;
    localparam logic [7:0] REG_CUR_LO = 8'h06;
    localparam logic [7:0] REG_CUR_HI = 8'h07;
    localparam logic [7:0] REG_VOLT_LO = 8'h08;
    localparam logic [7:0] REG_VOLT_HI = 8'h09;
    localparam logic [7:0] REG_TEMP_LO = 8'h0A;
    localparam logic [7:0] REG_TEMP_HI = 8'h0B;
    localparam logic [7:0] REG_ID_BASE = 8'h18;
    localparam logic [7:0] REG_RAM_BASE = 8'h20;
    localparam int unsigned RAM_BYTES = 32;
    localparam int unsigned MODE_SEL_EXT = 0;
    localparam int unsigned MODE_RES_LO = 1;
    localparam int unsigned MODE_CAL = 3;
    localparam int unsigned MODE_RUN = 4;
    localparam int unsigned CTRL_GPIO = 0;
    localparam int unsigned CTRL_CLR = 1;
    localparam int unsigned CTRL_CUR_DONE = 2;
    localparam int unsigned CTRL_VT_DONE = 3;
    localparam int unsigned CTRL_POR = 4;
    localparam logic [4:0] MODE_RST = 5'h00;
    localparam logic GPIO_LEVEL_RST = 1'b1;
    localparam logic POR_FLAG_RST = 1'b1;
    localparam logic DONE_FLAG_RST = 1'b1;
    localparam logic [3:0] DEV_ADDR_HI = 4'hE;
    localparam logic [2:0] DEV_SEL_RST = 3'h0;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_PTR = 3'b010,
        ST_WDATA = 3'b011,
        ST_RDATA = 3'b100,
        ST_ACK = 3'b101,
        ST_MACK = 3'b110
    } i2c_state_t;
endpackage : gauge_pkg

// file: hw/battery_gauge_core.sv
// Purpose: digital core of the battery monitor: gauge, sequencer, gpio, ram, id, I2C slave.
// Assumes: analogue results are held steady around their conversion end.
// Notes: rst_i is the power-on reset; the RAM is not reset.
`timescale 1ns/100ps
module battery_gauge_core #(
    parameter logic [2:0] DEV_SEL = gauge_pkg::DEV_SEL_RST
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic gpio_pin_i,
    output logic gpio_pin_o,
    output logic gpio_pin_oe_o,
    input wire logic ext_clk_i,
    input wire logic undervoltage_indication_i,
    input wire logic [55:0] id_nv_i,
    input wire logic [15:0] cur_adc_i,
    input wire logic [15:0] vt_adc_i,
    output logic offset_calibrate_o,
    output logic [1:0] gauge_resolution_o,
    output logic cur_conv_o,
    output logic vt_conv_o,
    output logic vt_temp_sel_o
);
    import gauge_pkg::*;

    // pin synchronisers; index 0 scl, 1 sda
    logic [1:0] bus_s1_q, bus_s2_q, bus_h1_q, bus_h2_q, bus_f_q, bus_p_q;
    logic gpio_s1_q, gpio_s2_q, ext_s1_q, ext_s2_q, ext_p_q, uv_s1_q, uv_s;
    logic [15:0] cur_s1_q, cur_s2_q, vt_s1_q, vt_s2_q;
    wire [1:0] bus_stable = ~(bus_s2_q ^ bus_h1_q) & ~(bus_h1_q ^ bus_h2_q);

    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
        begin
            bus_s1_q <= 2'h3;
            bus_s2_q <= 2'h3;
            bus_h1_q <= 2'h3;
            bus_h2_q <= 2'h3;
            bus_f_q <= 2'h3;
            bus_p_q <= 2'h3;
        end
        else
        begin
            bus_s1_q <= {sda_i, scl_i};
            bus_s2_q <= bus_s1_q;
            bus_h1_q <= bus_s2_q;
            bus_h2_q <= bus_h1_q;
            // a change must hold three samples (150 ns) before it counts
            bus_f_q <= (bus_f_q & ~bus_stable) | (bus_h2_q & bus_stable);
            bus_p_q <= bus_f_q;
        end

    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
        begin
            {gpio_s1_q, gpio_s2_q, ext_s1_q, ext_s2_q, ext_p_q} <= 5'h00;
            {uv_s1_q, uv_s} <= 2'h0;
            {cur_s1_q, cur_s2_q, vt_s1_q, vt_s2_q} <= 64'h0000_0000_0000_0000;
        end
        else
        begin
            {gpio_s2_q, gpio_s1_q} <= {gpio_s1_q, gpio_pin_i};
            {ext_p_q, ext_s2_q, ext_s1_q} <= {ext_s2_q, ext_s1_q, ext_clk_i};
            {uv_s, uv_s1_q} <= {uv_s1_q, undervoltage_indication_i};
            {cur_s2_q, cur_s1_q} <= {cur_s1_q, cur_adc_i};
            {vt_s2_q, vt_s1_q} <= {vt_s1_q, vt_adc_i};
        end

    wire scl_f = bus_f_q[0];
    wire sda_f = bus_f_q[1];
    wire scl_rise = scl_f & ~bus_p_q[0];
    wire scl_fall = ~scl_f & bus_p_q[0];
    wire start_c = scl_f & bus_p_q[0] & bus_p_q[1] & ~sda_f;
    wire stop_c = scl_f & bus_p_q[0] & ~bus_p_q[1] & sda_f;

    // control state
    logic [4:0] mode_q;
    logic gpio_level_q, por_flag_q, cur_flag_q, vt_flag_q;
    wire sel_ext = mode_q[MODE_SEL_EXT];
    wire [1:0] gauge_resolution = mode_q[MODE_RES_LO +: 2];
    wire gauge_run = mode_q[MODE_RUN];
    wire gg_act = gauge_run & ~uv_s;

    // time base
    logic [9:0] div_q;
    wire int_tick = (div_q == TB_DIV_M1);
    wire ext_tick = ext_s2_q & ~ext_p_q;
    wire tb_tick = sel_ext ? ext_tick : int_tick;

    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
            div_q <= 10'h000;
        else
            div_q <= int_tick ? 10'h000 : div_q + 10'h001;

    // current gauge
    logic [13:0] cc_q;
    logic [ACC_W-1:0] acc_q;
    logic [15:0] conv_cnt_q, cur_res_q;
    logic gg_clr_p;
    wire [13:0] len_m1 = (gauge_resolution == 2'h0) ? CUR_LEN14_M1 :
                         (gauge_resolution == 2'h1) ? CUR_LEN13_M1 : CUR_LEN12_M1;
    wire cur_done = tb_tick & gg_act & (cc_q >= len_m1);
    wire [15:0] res_mask = (gauge_resolution == 2'h0) ? 16'hFFFF :
                           (gauge_resolution == 2'h1) ? 16'hFFFE : 16'hFFFC;
    wire [15:0] cur_m = cur_s2_q & res_mask;
    wire [ACC_W-1:0] cur_ext = {{(ACC_W-16){cur_m[15]}}, cur_m};

    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
            cc_q <= 14'h0000;
        else if (!gg_act || cur_done)
            cc_q <= 14'h0000;
        else if (tb_tick)
            cc_q <= cc_q + 14'h0001;

    // clear wins over a coinciding conversion end
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
        begin
            acc_q <= '0;
            conv_cnt_q <= 16'h0000;
        end
        else if (gg_clr_p)
        begin
            acc_q <= '0;
            conv_cnt_q <= 16'h0000;
        end
        else if (cur_done)
        begin
            acc_q <= acc_q + cur_ext;
            conv_cnt_q <= conv_cnt_q + 16'h0001;
        end

    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
            cur_res_q <= 16'h0000;
        else if (cur_done)
            cur_res_q <= cur_m;

    // voltage / temperature sequencer
    logic [15:0] vt_cnt_q, volt_q, temp_q;
    logic vt_sel_q;
    wire vt_end = tb_tick & gg_act & (vt_cnt_q == VT_CONV_M1);

    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
            vt_cnt_q <= 16'h0000;
        else if (!gg_act || (tb_tick && vt_cnt_q == VT_PERIOD_M1))
            vt_cnt_q <= 16'h0000;
        else if (tb_tick)
            vt_cnt_q <= vt_cnt_q + 16'h0001;

    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
        begin
            vt_sel_q <= 1'b0;
            volt_q <= 16'h0000;
            temp_q <= 16'h0000;
        end
        else if (vt_end)
        begin
            vt_sel_q <= ~vt_sel_q;
            if (vt_sel_q)
                temp_q <= vt_s2_q;
            else
                volt_q <= vt_s2_q;
        end

    assign offset_calibrate_o = mode_q[MODE_CAL];
    assign gauge_resolution_o = gauge_resolution;
    assign cur_conv_o = gg_act;
    assign vt_conv_o = gg_act & (vt_cnt_q <= VT_CONV_M1);
    assign vt_temp_sel_o = vt_sel_q;

    // gpio: open drain
    wire gpio_en = gauge_run & ~por_flag_q & ~uv_s;
    wire gpio_rd = gpio_en & gpio_s2_q;
    assign gpio_pin_o = 1'b0;
    assign gpio_pin_oe_o = gpio_en & ~gpio_level_q;

    // identity, captured once after power-on release
    logic [55:0] id_q;
    logic [7:0] crc_q;
    logic id_loaded_q;

    function automatic logic [7:0] crc8(input logic [55:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 0; i < 56; i++)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[(i / 8) * 8 + 7 - (i % 8)]) ? CRC_POLY : 8'h00);
        return c;
    endfunction : crc8

    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
        begin
            id_q <= 56'h00_0000_0000_0000;
            crc_q <= 8'h00;
            id_loaded_q <= 1'b0;
        end
        else if (!id_loaded_q)
        begin
            id_q <= id_nv_i;
            crc_q <= crc8(id_nv_i);
            id_loaded_q <= 1'b1;
        end

    // RAM survives standby; content after power-on is undefined
    logic [7:0] ram_q [RAM_BYTES];

    // I2C slave
    i2c_state_t st_q, after_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q, ptr_q, rd_byte;
    logic nack_q;
    logic [15:0] snap_chg_q, snap_cnt_q, snap_cur_q, snap_volt_q, snap_temp_q;
    wire byte_end = scl_fall & (bit_q == BYTE_BITS);
    wire addr_hit = (shift_q[7:1] == {DEV_ADDR_HI, DEV_SEL});
    wire snap_p = byte_end & (st_q == ST_ADDR) & addr_hit & shift_q[0];
    wire wr_p = byte_end & (st_q == ST_WDATA);
    wire rd_load = scl_fall & (((st_q == ST_ACK) & (after_q == ST_RDATA)) |
                               ((st_q == ST_MACK) & ~nack_q));
    wire in_id = (ptr_q[7:3] == REG_ID_BASE[7:3]);
    wire in_ram = (ptr_q[7:5] == REG_RAM_BASE[7:5]);
    wire rd_ctrl = rd_load & (ptr_q == REG_CTRL);
    assign gg_clr_p = wr_p & (ptr_q == REG_CTRL) & shift_q[CTRL_CLR];

    always_comb
    begin
        rd_byte = 8'h00;
        case (ptr_q)
            REG_MODE: rd_byte = {3'h0, mode_q};
            REG_CTRL: rd_byte = {3'h0, por_flag_q, vt_flag_q, cur_flag_q, 1'b0, gpio_rd};
            REG_CHG_LO: rd_byte = snap_chg_q[7:0];
            REG_CHG_HI: rd_byte = snap_chg_q[15:8];
            REG_CNT_LO: rd_byte = snap_cnt_q[7:0];
            REG_CNT_HI: rd_byte = snap_cnt_q[15:8];
            REG_CUR_LO: rd_byte = snap_cur_q[7:0];
            REG_CUR_HI: rd_byte = snap_cur_q[15:8];
            REG_VOLT_LO: rd_byte = snap_volt_q[7:0];
            REG_VOLT_HI: rd_byte = snap_volt_q[15:8];
            REG_TEMP_LO: rd_byte = snap_temp_q[7:0];
            REG_TEMP_HI: rd_byte = snap_temp_q[15:8];
            default:
            begin
                if (in_id)
                    rd_byte = (ptr_q[2:0] == 3'h7) ? crc_q : id_q[ptr_q[2:0] * 8 +: 8];
                else if (in_ram)
                    rd_byte = ram_q[ptr_q[4:0]];
            end
        endcase
    end

    // snapshot at each read address so one transaction sees one instant
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
            {snap_chg_q, snap_cnt_q, snap_cur_q, snap_volt_q, snap_temp_q} <= '0;
        else if (snap_p)
        begin
            snap_chg_q <= acc_q[ACC_W-1:CHG_LSB];
            snap_cnt_q <= conv_cnt_q;
            snap_cur_q <= cur_res_q;
            snap_volt_q <= volt_q;
            snap_temp_q <= temp_q;
        end

    always_ff @(posedge clk_i)
        if (wr_p && in_ram)
            ram_q[ptr_q[4:0]] <= shift_q;

    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
        begin
            mode_q <= MODE_RST;
            gpio_level_q <= GPIO_LEVEL_RST;
            por_flag_q <= POR_FLAG_RST;
        end
        else if (wr_p && ptr_q == REG_MODE)
            mode_q <= shift_q[4:0];
        else if (wr_p && ptr_q == REG_CTRL)
        begin
            gpio_level_q <= shift_q[CTRL_GPIO];
            por_flag_q <= shift_q[CTRL_POR];
        end

    // a conversion end wins over the clearing read
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
        begin
            cur_flag_q <= DONE_FLAG_RST;
            vt_flag_q <= DONE_FLAG_RST;
        end
        else
        begin
            cur_flag_q <= cur_done | (cur_flag_q & ~rd_ctrl);
            vt_flag_q <= vt_end | (vt_flag_q & ~rd_ctrl);
        end

    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i)
        begin
            st_q <= ST_IDLE;
            after_q <= ST_IDLE;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            ptr_q <= 8'h00;
            nack_q <= 1'b0;
            sda_oe_o <= 1'b0;
        end
        else if (start_c)
        begin
            st_q <= ST_ADDR;
            bit_q <= 4'h0;
            sda_oe_o <= 1'b0;
        end
        else if (stop_c)
        begin
            st_q <= ST_IDLE;
            sda_oe_o <= 1'b0;
        end
        else if (scl_rise)
        begin
            if (st_q == ST_ADDR || st_q == ST_PTR || st_q == ST_WDATA)
                shift_q <= {shift_q[6:0], sda_f};
            if (st_q == ST_MACK)
                nack_q <= sda_f;
            if (st_q != ST_ACK && st_q != ST_MACK)
                bit_q <= bit_q + 4'h1;
        end
        else if (scl_fall)
        begin
            case (st_q)
                ST_ADDR, ST_PTR, ST_WDATA:
                begin
                    if (bit_q == BYTE_BITS)
                    begin
                        st_q <= (st_q == ST_ADDR && !addr_hit) ? ST_IDLE : ST_ACK;
                        sda_oe_o <= (st_q != ST_ADDR) || addr_hit;
                        after_q <= (st_q == ST_ADDR && shift_q[0]) ? ST_RDATA :
                                   (st_q == ST_ADDR) ? ST_PTR : ST_WDATA;
                        if (st_q == ST_PTR)
                            ptr_q <= shift_q;
                        if (st_q == ST_WDATA)
                            ptr_q <= ptr_q + 8'h01;
                    end
                end
                ST_ACK:
                begin
                    bit_q <= 4'h0;
                    st_q <= after_q;
                    shift_q <= rd_byte;
                    sda_oe_o <= (after_q == ST_RDATA) & ~rd_byte[7];
                end
                ST_RDATA:
                begin
                    if (bit_q == BYTE_BITS)
                    begin
                        st_q <= ST_MACK;
                        sda_oe_o <= 1'b0;
                        ptr_q <= ptr_q + 8'h01;
                    end
                    else
                    begin
                        shift_q <= {shift_q[6:0], 1'b0};
                        sda_oe_o <= ~shift_q[6];
                    end
                end
                ST_MACK:
                begin
                    bit_q <= 4'h0;
                    st_q <= nack_q ? ST_IDLE : ST_RDATA;
                    shift_q <= rd_byte;
                    sda_oe_o <= ~nack_q & ~rd_byte[7];
                end
                default: st_q <= ST_IDLE;
            endcase
        end

    assign sda_o = 1'b0;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_acc_add: assert property ((cur_done && !gg_clr_p) |=> acc_q == $past(acc_q + cur_ext))
        else $error("accumulator did not add the conversion result");
    a_cnt_step: assert property ((cur_done && !gg_clr_p) |=>
        conv_cnt_q == $past(conv_cnt_q) + 16'h0001)
        else $error("conversion counter did not step by one");
    a_cur_load: assert property (cur_done |=> cur_res_q == $past(cur_m))
        else $error("current result not loaded at conversion end");
    // ticks are sparse, so check each tick's step rather than the end value alone
    a_conv_len: assert property ((tb_tick && gg_act && !cur_done) |=>
        cc_q == $past(cc_q) + 14'h0001)
        else $error("current conversion length counter skipped a tick");
    a_uv_freeze: assert property ((uv_s && !gg_clr_p) |=> $stable(acc_q) && $stable(conv_cnt_q))
        else $error("gauge moved during undervoltage");
    a_clear_zero: assert property (gg_clr_p |=> acc_q == '0 && conv_cnt_q == 16'h0000)
        else $error("gauge clear did not zero the gauge");
    a_flag_set: assert property (cur_done |=> cur_flag_q)
        else $error("done flag not set after conversion");
    a_gpio_release: assert property ((!gauge_run || por_flag_q || uv_s) |->
        !gpio_pin_oe_o && !gpio_rd)
        else $error("gpio driven or read while inactive");
    a_vt_alt: assert property (vt_end |=> vt_sel_q != $past(vt_sel_q))
        else $error("sequencer did not alternate");
    a_addr_ack: assert property ((byte_end && st_q == ST_ADDR && addr_hit) |=>
        sda_oe_o && st_q == ST_ACK)
        else $error("matching address not acknowledged");
    a_ptr_step: assert property ((wr_p && !start_c && !stop_c) |=>
        ptr_q == $past(ptr_q) + 8'h01)
        else $error("pointer did not advance after write");
endmodule : battery_gauge_core

// file: tb/i2c_host_model.sv
// Purpose: I2C bus master standing in for the host controller.
// Assumes: pull-ups on both lines; the bench resolves SDA from every pull enable.
// Notes: SCL high 10 clk, low 13 clk, about 870 kbit/s, above fast mode; 3 clk data hold after SCL falls.
`timescale 1ns/100ps
module i2c_host_model (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_pull_o
);
    initial
    begin
        scl_o = 1'b1;
        sda_pull_o = 1'b0;
    end
    task automatic half();
        repeat (10) @(negedge clk_i);
    endtask : half
    // sda moves only while scl is low, so no false start or stop is seen
    task automatic bit_io(input logic b, output logic r);
        repeat (3) @(negedge clk_i);
        sda_pull_o = ~b;
        half();
        scl_o = 1'b1;
        half();
        r = sda_i;
        scl_o = 1'b0;
    endtask : bit_io
    task automatic start();
        repeat (3) @(negedge clk_i);
        sda_pull_o = 1'b0;
        half();
        scl_o = 1'b1;
        half();
        sda_pull_o = 1'b1;
        half();
        scl_o = 1'b0;
    endtask : start
    task automatic stop();
        repeat (3) @(negedge clk_i);
        sda_pull_o = 1'b1;
        half();
        scl_o = 1'b1;
        half();
        sda_pull_o = 1'b0;
        half();
    endtask : stop
    // msb first, then the ninth bit: released to hear an ack, or our own ack
    task automatic xfer(input logic [7:0] w, input logic ack_in, output logic [7:0] r,
        output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(w[i], r[i]);
        bit_io(ack_in, ack);
    endtask : xfer
endmodule : i2c_host_model

// file: tb/battery_gauge_core_tb.sv
// Purpose: self-checking bench of the battery gauge core over its I2C port.
// Assumes: 12-bit mode with a 400 ns external time base keeps conversions short.
// Notes: all inputs except ext_clk_i move at the falling clock edge.
`timescale 1ns/100ps
module battery_gauge_core_tb;
    import gauge_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic ext_clk_i = 1'b0;
    logic uv = 1'b0;
    logic [55:0] id_nv = 56'h0123_4567_89AB_CD; // arbitrary identity
    logic [15:0] cur_adc = 16'h8003;
    logic scl, sda_pull, sda_oe, gpio_oe, cal;
    logic [1:0] res;
    logic cur_conv, vt_conv, vt_sel, sda_drv, gpio_drv;
    wire sda_line = ~(sda_oe | sda_pull);
    wire gpio_line = ~gpio_oe;
    logic [7:0] wb [0:8];
    logic [7:0] rb [0:8];
    int num_errors = 0;
    int compares = 0;
    initial forever #25 clk_i = ~clk_i;
    initial
    begin
        #37;
        forever #200 ext_clk_i = ~ext_clk_i;
    end
    i2c_host_model hm (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl), .sda_pull_o(sda_pull));
    battery_gauge_core i_dut (.clk_i(clk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_drv), .sda_oe_o(sda_oe), .gpio_pin_i(gpio_line), .gpio_pin_o(gpio_drv),
        .gpio_pin_oe_o(gpio_oe), .ext_clk_i(ext_clk_i), .undervoltage_indication_i(uv),
        .id_nv_i(id_nv), .cur_adc_i(cur_adc), .vt_adc_i(16'h1234), .offset_calibrate_o(cal),
        .gauge_resolution_o(res), .cur_conv_o(cur_conv), .vt_conv_o(vt_conv),
        .vt_temp_sel_o(vt_sel));
    task automatic end_sim();
        $display("compares=%0d mismatches=%0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one transaction: write n bytes of wb, or read n bytes into rb
    task automatic xact(input logic [7:0] p, input int n, input logic rd);
        logic a;
        logic [7:0] r;
        hm.start();
        hm.xfer(8'hE0, 1'b1, r, a);
        chk(8'(a), 8'h00);
        hm.xfer(p, 1'b1, r, a);
        chk(8'(a), 8'h00);
        if (rd)
        begin
            hm.start();
            hm.xfer(8'hE1, 1'b1, r, a);
            chk(8'(a), 8'h00);
        end
        for (int i = 0; i < n; i++)
        begin
            hm.xfer(rd ? 8'hFF : wb[i], rd ? (i == n - 1) : 1'b1, rb[i], a);
            if (!rd)
                chk(8'(a), 8'h00);
        end
        hm.stop();
    endtask : xact
    function automatic logic [7:0] crc8(input logic [55:0] v);
        logic [7:0] c;
        c = 8'h00;
        for (int k = 0; k < 56; k++)
            c = {c[6:0], 1'b0} ^ ((c[7] ^ v[8 * (k / 8) + 7 - k % 8]) ? 8'h07 : 8'h00);
        return c;
    endfunction : crc8
    task automatic t_reset();
        logic a;
        logic [7:0] r;
        xact(REG_MODE, 2, 1'b1);
        chk(rb[0], 8'h00);
        chk(rb[1], 8'h1C);
        xact(REG_CTRL, 1, 1'b1);
        chk(rb[0], 8'h10);
        chk({6'h00, sda_drv, gpio_drv}, 8'h00);
        hm.start();
        hm.xfer(8'hE2, 1'b1, r, a);
        chk(8'(a), 8'h01);
        hm.stop();
        $display("test reset done");
    endtask : t_reset
    task automatic t_gauge();
        wb[0] = 8'h15;
        xact(REG_MODE, 1, 1'b0);
        chk(8'(cur_conv), 8'h01);
        chk(8'(vt_conv), 8'h01);
        chk(8'(vt_sel), 8'h00);
        repeat (30000) @(negedge clk_i);
        xact(REG_CNT_LO, 2, 1'b1);
        chk(rb[0] | rb[1], 8'h00);
        repeat (4000) @(negedge clk_i);
        xact(REG_CTRL, 7, 1'b1);
        chk(rb[0] & 8'h04, 8'h04);
        chk(rb[0] & 8'h08, 8'h00);
        chk(rb[1], 8'hF8);
        chk(rb[2], 8'hFF);
        chk(rb[3], 8'h01);
        chk(rb[4], 8'h00);
        chk(rb[5], 8'h00);
        chk(rb[6], 8'h80);
        uv = 1'b1;
        repeat (10) @(negedge clk_i);
        chk(8'(cur_conv), 8'h00);
        uv = 1'b0;
        wb[0] = 8'h03;
        xact(REG_CTRL, 1, 1'b0);
        xact(REG_CHG_LO, 4, 1'b1);
        chk(rb[0] | rb[1] | rb[2] | rb[3], 8'h00);
        $display("test gauge done");
    endtask : t_gauge
    task automatic t_modes();
        logic [7:0] m [0:3] = '{8'h00, 8'h02, 8'h04, 8'h08};
        for (int i = 0; i < 4; i++)
        begin
            wb[0] = m[i];
            xact(REG_MODE, 1, 1'b0);
            chk({5'h00, cal, res}, {5'h00, m[i][3:1]});
        end
        $display("test modes done");
    endtask : t_modes
    task automatic t_gpio();
        wb[0] = 8'h11;
        wb[1] = 8'h00;
        xact(REG_MODE, 2, 1'b0);
        chk(8'(gpio_oe), 8'h01);
        xact(REG_CTRL, 1, 1'b1);
        chk(rb[0] & 8'h01, 8'h00);
        wb[0] = 8'h01;
        xact(REG_CTRL, 1, 1'b0);
        chk(8'(gpio_oe), 8'h00);
        xact(REG_CTRL, 1, 1'b1);
        chk(rb[0] & 8'h01, 8'h01);
        wb[1] = 8'h00;
        xact(REG_MODE, 2, 1'b0);
        chk(8'(gpio_oe), 8'h00);
        xact(REG_CTRL, 1, 1'b1);
        chk(rb[0] & 8'h01, 8'h00);
        $display("test gpio done");
    endtask : t_gpio
    task automatic t_mem();
        wb[0] = 8'hA5;
        wb[1] = 8'h5A;
        wb[2] = 8'h0F;
        xact(8'h3D, 3, 1'b0);
        xact(8'h17, 2, 1'b0);
        xact(8'h3D, 3, 1'b1);
        for (int i = 0; i < 3; i++)
            chk(rb[i], wb[i]);
        xact(8'h17, 9, 1'b1);
        chk(rb[0], 8'h00);
        for (int i = 0; i < 7; i++)
            chk(rb[i + 1], id_nv[8 * i +: 8]);
        chk(rb[8], crc8(id_nv));
        $display("test memory done");
    endtask : t_mem
    initial
    begin
        // 90k clocks, well above the expected run length
        #4_500_000;
        num_errors++;
        $display("MISMATCH t=%0t timeout got=%h exp=%h", $time, 1'b0, 1'b1);
        end_sim();
    end
    initial
    begin
        repeat (12) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (10) @(negedge clk_i);
        t_reset();
        t_gauge();
        t_modes();
        t_gpio();
        t_mem();
        end_sim();
    end
endmodule : battery_gauge_core_tb
